/* flash_app_write_defines.svh */
// Notes on behaviour
// - store to flash address starts byte write
// - write acts only with flash write enable
// - cpu held waiting while byte programs
// - peripherals keep running during the stall
// - interrupts stay pending until write ends
// - flash reads return data without waiting
// - unlock code 47h/E2h sets, other clears
// - unlock bit 7 reads flash enable
// - timeout flag set on expiry, cleared
// - two-bit timeout select, expiry releases cpu
// - 65h sets wide-area flag, other clears
// - command bit 0 reads wide-area flag
// - lock bit restricts low area access
// - big program area writable only wide-area
// - free sector needs only write enable
// - top configuration byte never accessible
`ifndef FLASH_APP_WRITE_DEFINES_SVH
`define FLASH_APP_WRITE_DEFINES_SVH
// ==========================================================
// register offsets
`define SFR_SOFT_CMD_ADDR 8'h97
`define SFR_UNLOCK_ADDR   8'hC9
`define SFR_AUX_CTL2_ADDR 8'hF7
// ==========================================================
// command codes
`define CODE_FLASH_WE     8'h47
`define CODE_EEPROM_WE    8'hE2
`define CODE_WIDE_AREA    8'h65
// ==========================================================
// field positions
`define BIT_FLASH_WE      7
`define BIT_TIMEOUT       6
`define BIT_EEPROM_WE     5
`define BIT_WIDE_AREA     0
`define BIT_LOW_LOCK      1
`define AUX_CTL2_RESET    8'h06
// ==========================================================
// address map
`define ADDR_TOP_WRITE    16'h3FFE
`define ADDR_CFG_HIGH     16'h3FFF
`define ADDR_LOCK_END     16'h01FF
`define ADDR_ALL_LO       16'h0200
`define ADDR_ALL_HI       16'h3EFF
`define ADDR_FREE_HI      16'h3FEF
`define ADDR_CFG_OPEN_HI  16'h3FF7
// ==========================================================
// timing, 40 MHz clock
`define CLK_HZ            40000000
`define PROG_TIME_US      1000
`define TO1_TIME_US       1500
`define TO2_TIME_US       5800
`define TO3_TIME_US       11700
`define US_CYC(t)         ((t) * (`CLK_HZ / 1000000))
`endif

/* flash_app_write_pkg.sv */
package flash_app_write_pkg;
	// sfr bus request from the cpu core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;
	// external-data store request
	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  data;
	} store_req_t;
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PROG
	} prog_state_t;
endpackage

/* flash_timeout_counter.sv */
`timescale 1ns/1ps
`include "flash_app_write_defines.svh"
module flash_timeout_counter #(
	parameter int WIDTH = 20
) (
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	// control
	input  wire logic             run_i,     // count while high
	input  wire logic [WIDTH-1:0] limit_i,   // terminal count
	// status
	output logic                  hit_o      // one-cycle pulse at limit
);
	// ==========================================================
	// counter
	logic [WIDTH-1:0] count; // cycles elapsed in this run
	// restarts from zero whenever run drops
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= '0;
			hit_o <= 1'b0;
		end else if (!run_i) begin
			count <= '0;
			hit_o <= 1'b0;
		end else begin
			count <= count + 1'b1;
			hit_o <= (count == limit_i - 1'b1);
		end
	end
endmodule

/* flash_app_write_access.sv */
`timescale 1ns/1ps
`include "flash_app_write_defines.svh"
module flash_app_write_access
	import flash_app_write_pkg::*;
#(
	parameter int PROG_CYC = `US_CYC(`PROG_TIME_US),
	parameter int TO1_CYC  = `US_CYC(`TO1_TIME_US),
	parameter int TO2_CYC  = `US_CYC(`TO2_TIME_US),
	parameter int TO3_CYC  = `US_CYC(`TO3_TIME_US),
	parameter int CW       = 20
) (
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	// sfr bus
	input  wire sfr_req_t    sfr_i,
	output logic [7:0]       sfr_rdata_o,
	// external-data store / load
	input  wire store_req_t  store_i,
	input  wire logic [15:0] rd_addr_i,
	input  wire logic        rd_code_i,
	output logic [7:0]       rd_data_o,
	output logic             rd_ok_o,
	// flash array port
	input  wire logic [7:0]  arr_rdata_i,
	input  wire logic        arr_done_i,
	output logic             arr_prog_o,
	output logic [15:0]      arr_addr_o,
	output logic [7:0]       arr_wdata_o,
	// configuration and cpu control
	input  wire logic [7:0]  cfg_high_i,
	output logic             cpu_wait_o,
	output logic             eeprom_we_o
);
	// ==========================================================
	// reset synchroniser
	logic rst_meta;
	logic rst_sync_n;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// ==========================================================
	// access decode, shared by read and write paths
	function automatic logic area_ok(input logic [15:0] a, input logic wide,
		input logic lock, input logic is_code);
		if (a > `ADDR_TOP_WRITE)
			return 1'b0;
		if (a <= `ADDR_LOCK_END)
			return !lock && (is_code || wide);
		if (a <= `ADDR_ALL_HI)
			return is_code || wide;
		if (a <= `ADDR_FREE_HI)
			return 1'b1;
		if (a <= `ADDR_CFG_OPEN_HI)
			return 1'b1;
		return is_code || wide;
	endfunction

	// ==========================================================
	// flags
	logic       flash_write_enable_flag;  // unlock bit 7
	logic       eeprom_write_enable_flag; // unlock bit 5
	logic       write_timeout_flag;       // unlock bit 6
	logic       wide_area_access_flag;    // command bit 0
	logic [7:0] aux_control_2;            // timeout select in bits 2..1
	logic       to_hit;                   // watchdog expiry pulse
	prog_state_t state;
	logic       low_area_lock;
	assign low_area_lock = cfg_high_i[`BIT_LOW_LOCK];

	// unlock register; every code write rewrites both enables at once
	always_ff @(posedge clock_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			flash_write_enable_flag  <= 1'b0;
			eeprom_write_enable_flag <= 1'b0;
		end else if (sfr_i.wr && sfr_i.addr == `SFR_UNLOCK_ADDR) begin
			flash_write_enable_flag  <= (sfr_i.wdata == `CODE_FLASH_WE);
			eeprom_write_enable_flag <= (sfr_i.wdata == `CODE_EEPROM_WE);
		end
	end

	// timeout flag: expiry set beats the clear from enables dropping
	always_ff @(posedge clock_i or negedge rst_sync_n) begin
		if (!rst_sync_n)
			write_timeout_flag <= 1'b0;
		else if (to_hit)
			write_timeout_flag <= 1'b1;
		else if (!flash_write_enable_flag && !eeprom_write_enable_flag)
			write_timeout_flag <= 1'b0;
	end

	// software command register
	always_ff @(posedge clock_i or negedge rst_sync_n) begin
		if (!rst_sync_n)
			wide_area_access_flag <= 1'b0;
		else if (sfr_i.wr && sfr_i.addr == `SFR_SOFT_CMD_ADDR)
			wide_area_access_flag <= (sfr_i.wdata == `CODE_WIDE_AREA);
	end

	// aux control 2, plain storage
	always_ff @(posedge clock_i or negedge rst_sync_n) begin
		if (!rst_sync_n)
			aux_control_2 <= `AUX_CTL2_RESET;
		else if (sfr_i.wr && sfr_i.addr == `SFR_AUX_CTL2_ADDR)
			aux_control_2 <= sfr_i.wdata;
	end

	// sfr readback, registered
	always_ff @(posedge clock_i or negedge rst_sync_n) begin
		if (!rst_sync_n)
			sfr_rdata_o <= 8'h00;
		else if (sfr_i.rd) begin
			unique case (sfr_i.addr)
				`SFR_UNLOCK_ADDR: sfr_rdata_o <= {flash_write_enable_flag,
					write_timeout_flag, eeprom_write_enable_flag, 5'h00};
				`SFR_SOFT_CMD_ADDR: sfr_rdata_o <= {7'h00, wide_area_access_flag};
				`SFR_AUX_CTL2_ADDR: sfr_rdata_o <= aux_control_2;
				default:         sfr_rdata_o <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// watchdog limit select
	logic [CW-1:0] to_limit;
	logic [1:0]    write_timeout_select;
	assign write_timeout_select = aux_control_2[2:1];
	always_comb begin
		unique case (write_timeout_select)
			2'b00: to_limit = CW'(PROG_CYC);
			2'b01: to_limit = CW'(TO1_CYC);
			2'b10: to_limit = CW'(TO2_CYC);
			2'b11: to_limit = CW'(TO3_CYC);
		endcase
	end

	flash_timeout_counter #(
		.WIDTH (CW)
	) u_watchdog (
		.clock_i (clock_i),
		.rst_n_i (rst_sync_n),
		.run_i   (state == ST_PROG && write_timeout_select != 2'b00),
		.limit_i (to_limit),
		.hit_o   (to_hit)
	);

	// ==========================================================
	// write sequencer; only cpu is stalled, other logic keeps its clock
	logic accept;
	assign accept = store_i.wr && flash_write_enable_flag
		&& area_ok(store_i.addr, wide_area_access_flag, low_area_lock, 1'b0);
	always_ff @(posedge clock_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state       <= ST_IDLE;
			cpu_wait_o  <= 1'b0;
			arr_prog_o  <= 1'b0;
			arr_addr_o  <= 16'h0000;
			arr_wdata_o <= 8'h00;
		end else begin
			unique case (state)
				ST_IDLE: if (accept && state == ST_IDLE) begin
					state       <= ST_PROG;
					cpu_wait_o  <= 1'b1;
					arr_prog_o  <= 1'b1;
					arr_addr_o  <= store_i.addr;
					arr_wdata_o <= store_i.data;
				end // rejected store leaves all unchanged
				ST_PROG: if (arr_done_i || to_hit) begin
					state      <= ST_IDLE;
					cpu_wait_o <= 1'b0;
					arr_prog_o <= 1'b0;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// read path, one registered cycle, no wait
	always_ff @(posedge clock_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rd_data_o <= 8'h00;
			rd_ok_o   <= 1'b0;
		end else begin
			rd_ok_o   <= area_ok(rd_addr_i, wide_area_access_flag, low_area_lock, rd_code_i);
			rd_data_o <= area_ok(rd_addr_i, wide_area_access_flag, low_area_lock,
				rd_code_i) ? arr_rdata_i : 8'h00;
		end
	end

	always_ff @(posedge clock_i or negedge rst_sync_n) begin
		if (!rst_sync_n)
			eeprom_we_o <= 1'b0;
		else
			eeprom_we_o <= eeprom_write_enable_flag;
	end

	// ==========================================================
	// checks
	chk_reject_no_stall: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
		(state == ST_IDLE && store_i.wr && !flash_write_enable_flag) |=> !cpu_wait_o)
		else $error("rejected store stalled cpu");
	chk_accept_stall: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
		(state == ST_IDLE && accept) |=> cpu_wait_o && arr_prog_o)
		else $error("accepted store not stalled");
	chk_unlock_code: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
		(sfr_i.wr && sfr_i.addr == `SFR_UNLOCK_ADDR && sfr_i.wdata != `CODE_FLASH_WE)
		|=> !flash_write_enable_flag)
		else $error("unlock flag not cleared");
	chk_timeout_sets: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
		to_hit |=> write_timeout_flag && !cpu_wait_o)
		else $error("timeout did not release");
	chk_timeout_clear: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
		(!flash_write_enable_flag && !eeprom_write_enable_flag && !to_hit)
		|=> !write_timeout_flag)
		else $error("timeout flag stuck");
	chk_wide_code: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
		(sfr_i.wr && sfr_i.addr == `SFR_SOFT_CMD_ADDR) |=>
		wide_area_access_flag == ($past(sfr_i.wdata) == `CODE_WIDE_AREA))
		else $error("wide-area flag wrong");
	chk_cfg_high: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
		(rd_addr_i == `ADDR_CFG_HIGH) |=> !rd_ok_o)
		else $error("config byte readable");
	chk_area_guard: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
		(state == ST_IDLE && store_i.wr && !wide_area_access_flag
		&& store_i.addr >= `ADDR_ALL_LO && store_i.addr <= `ADDR_ALL_HI) |=> !arr_prog_o)
		else $error("protected area written");
	cov_write: cover property (@(posedge clock_i) disable iff (!rst_sync_n)
		cpu_wait_o ##1 !cpu_wait_o);
	cov_timeout: cover property (@(posedge clock_i) disable iff (!rst_sync_n) to_hit);
	cov_free_read: cover property (@(posedge clock_i) disable iff (!rst_sync_n) rd_ok_o);
endmodule

/* flash_array_model.sv */
`timescale 1ns/1ps
module flash_array_model #(
	parameter int DONE_CYC = 20   // cycles a byte takes to program
) (
	// clock
	input  wire logic        clock_i,
	// program side
	input  wire logic        prog_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        hold_i,    // high keeps the cell busy while it stays high
	output logic             done_o,
	// read side
	input  wire logic [15:0] rd_addr_i,
	output logic [7:0]       rdata_o
);
	// ==========================================================
	// storage, erased cells read FFh
	logic [7:0] mem [0:16383];
	int         cnt;
	initial begin
		for (int i = 0; i < 16384; i++) begin
			mem[i] = 8'hFF;
		end
		done_o = 1'b0;
		cnt = 0;
	end
	// reads are combinational so the block needs no wait
	assign rdata_o = mem[rd_addr_i[13:0]];
	// ==========================================================
	// programming timer, byte lands with the done pulse
	always @(posedge clock_i) begin
		if (prog_i && !done_o && !hold_i) begin
			cnt <= cnt + 1;
			if (cnt == DONE_CYC - 1) begin
				done_o <= 1'b1;
				mem[addr_i[13:0]] <= wdata_i;
			end
		end else begin
			done_o <= 1'b0;
			if (!prog_i) begin
				cnt <= 0;
			end
		end
	end
endmodule

/* flash_app_write_access_tb.sv */
`timescale 1ns/1ps
module flash_app_write_access_tb;
	import flash_app_write_pkg::*;
	// ==========================================================
	// stimulus and observed signals
	logic        clock_i = 1'b0;
	logic        rst_n_i = 1'b0;
	sfr_req_t    sfr = '0;
	store_req_t  st = '0;
	logic [15:0] rd_addr = 16'h0000;
	logic        rd_code = 1'b0;
	logic [7:0]  cfg_high = 8'h00;
	logic        hold = 1'b0;       // stalls the array model
	logic [7:0]  sfr_rdata, rd_data, arr_rdata, arr_wdata, v;
	logic        rd_ok, arr_done, arr_prog, cpu_wait, eeprom_we;
	logic [15:0] arr_addr;
	int          fail_count = 0;
	int          checks_done = 0;
	int          n;
	int          to_cyc [1:3] = '{30, 40, 50};
	always #12.5 clock_i = ~clock_i;
	// ==========================================================
	// design and array model, counts shortened
	flash_app_write_access #(.PROG_CYC(20), .TO1_CYC(30), .TO2_CYC(40), .TO3_CYC(50)) u_dut (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .sfr_i(sfr), .sfr_rdata_o(sfr_rdata),
		.store_i(st), .rd_addr_i(rd_addr), .rd_code_i(rd_code), .rd_data_o(rd_data),
		.rd_ok_o(rd_ok), .arr_rdata_i(arr_rdata), .arr_done_i(arr_done),
		.arr_prog_o(arr_prog), .arr_addr_o(arr_addr), .arr_wdata_o(arr_wdata),
		.cfg_high_i(cfg_high), .cpu_wait_o(cpu_wait), .eeprom_we_o(eeprom_we));
	flash_array_model #(.DONE_CYC(20)) u_array (
		.clock_i(clock_i), .prog_i(arr_prog), .addr_i(arr_addr), .wdata_i(arr_wdata),
		.hold_i(hold), .done_o(arr_done), .rd_addr_i(rd_addr), .rdata_o(arr_rdata));
	// ==========================================================
	// shared tasks, inputs move 1 ns after the edge
	task automatic tick;
		@(posedge clock_i);
		#1;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		tick;
		sfr = '{1'b1, 1'b0, a, d};
		tick;
		sfr.wr = 1'b0;
	endtask
	task automatic sfr_rd(input logic [7:0] a);
		tick;
		sfr = '{1'b0, 1'b1, a, 8'h00};
		tick;
		sfr.rd = 1'b0;
		v = sfr_rdata;
	endtask
	// store one byte, check the stall, wait it out under a bound
	task automatic store(input logic [15:0] a, input logic [7:0] d, input logic stall);
		tick;
		st = '{1'b1, a, d};
		tick;
		st.wr = 1'b0;
		chk("cpu_wait", {7'h00, stall}, {7'h00, cpu_wait});
		chk("arr_prog", {7'h00, stall}, {7'h00, arr_prog});
		if (stall) begin
			chk("arr_wdata", d, arr_wdata);
			chk("arr_addr lo", a[7:0], arr_addr[7:0]);
			chk("arr_addr hi", a[15:8], arr_addr[15:8]);
		end
		n = 0;
		while (cpu_wait === 1'b1 && n < 200) begin
			tick;
			n++;
		end
		chk("cpu_wait end", 8'h00, {7'h00, cpu_wait});
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic c, input logic [7:0] d, input logic ok);
		tick;
		rd_addr = a;
		rd_code = c;
		tick;
		chk("rd_data", d, rd_data);
		chk("rd_ok", {7'h00, ok}, {7'h00, rd_ok});
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset;
		sfr_rd(8'hC9);
		chk("unlock flags", 8'h00, v & 8'hE0);
		sfr_rd(8'hF7);
		chk("timeout select", 8'h06, v & 8'h06);
		sfr_rd(8'h97);
		chk("wide flag", 8'h00, v & 8'h01);
	endtask
	task automatic t_codes;
		sfr_wr(8'hC9, 8'h47);
		sfr_rd(8'hC9);
		chk("flash enable", 8'h80, v & 8'hA0);
		sfr_wr(8'hC9, 8'hE2);
		sfr_rd(8'hC9);
		chk("eeprom flag", 8'h20, v & 8'hA0);
		chk("eeprom enable", 8'h01, {7'h00, eeprom_we});
		sfr_wr(8'hC9, 8'h5A);
		sfr_rd(8'hC9);
		chk("flags cleared", 8'h00, v & 8'hA0);
		sfr_wr(8'h97, 8'h65);
		sfr_rd(8'h97);
		chk("wide set", 8'h01, v & 8'h01);
		sfr_wr(8'h97, 8'h64);
		sfr_rd(8'h97);
		chk("wide clear", 8'h00, v & 8'h01);
	endtask
	task automatic t_areas;
		store(16'h3F01, 8'hA5, 1'b0);
		rd_chk(16'h3F01, 1'b0, 8'hFF, 1'b1);
		sfr_wr(8'hC9, 8'h47);
		store(16'h3F00, 8'h5A, 1'b1);
		rd_chk(16'h3F00, 1'b0, 8'h5A, 1'b1);
		rd_chk(16'h3F00, 1'b1, 8'h5A, 1'b1);
		store(16'h2000, 8'h11, 1'b0);
		sfr_wr(8'h97, 8'h65);
		store(16'h2000, 8'h11, 1'b1);
		rd_chk(16'h2000, 1'b0, 8'h11, 1'b1);
		store(16'h3FFF, 8'h22, 1'b0);
		rd_chk(16'h3FFF, 1'b1, 8'h00, 1'b0);
		cfg_high = 8'h02;
		store(16'h0100, 8'h33, 1'b0);
		rd_chk(16'h0100, 1'b1, 8'h00, 1'b0);
		cfg_high = 8'h00;
		rd_chk(16'h0100, 1'b1, 8'hFF, 1'b1);
		sfr_wr(8'h97, 8'h00);
		rd_chk(16'h0100, 1'b0, 8'h00, 1'b0);
		sfr_wr(8'hC9, 8'h00);
	endtask
	// every watchdog span with a stuck array, then watchdog off
	task automatic t_timeout;
		hold = 1'b1;
		for (int k = 1; k <= 3; k++) begin
			sfr_wr(8'hF7, 8'(k << 1));
			sfr_wr(8'hC9, 8'h47);
			store(16'h3F10, 8'h44, 1'b1);
			chk("timeout span", 8'h01, 8'(n >= to_cyc[k] - 3 && n <= to_cyc[k] + 3));
			sfr_rd(8'hC9);
			chk("timeout set", 8'h40, v & 8'h40);
			sfr_wr(8'hC9, 8'h00);
			sfr_rd(8'hC9);
			chk("timeout clear", 8'h00, v & 8'h40);
		end
		sfr_wr(8'hF7, 8'h00);
		sfr_wr(8'hC9, 8'h47);
		fork
			begin
				#(100 * 25);
				hold = 1'b0;
			end
		join_none
		store(16'h3F11, 8'h66, 1'b1);
		chk("no watchdog", 8'h01, 8'(n >= 95));
		rd_chk(16'h3F11, 1'b0, 8'h66, 1'b1);
		sfr_wr(8'hC9, 8'h00);
	endtask
	// ==========================================================
	// verdict, reached from the sequence or the watchdog
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clock_i);
		#1;
		rst_n_i = 1'b1;
		repeat (3) tick;
		t_reset;
		t_codes;
		t_areas;
		t_timeout;
		complete_run;
	end
	// a few hundred cycles suffice, so 200 us means a hang
	initial begin
		#200000;
		fail_count++;
		complete_run;
	end
endmodule
